// *** flash_seq_map.svh ***
// Register offsets, field positions, reset values and timing counts for the flash command sequencer.
// Assumes a byte-wide register port on a 20 MHz clock; included by bare name.
// Function
// - The first step of a sequence is an array write, whose address and data are latched.
// - Erase and blank check ignore the data; page erase acts on the 512-byte page of the address.
// - The smallest erasable unit is a whole 512-byte page.
// - The command register accepts 0x05 blank check, 0x20 byte program and 0x25 burst program.
// - The command register accepts 0x40 page erase and 0x41 mass erase, the only erase codes.
// - Writing 1 to the command-buffer-empty flag clears it and launches the buffered command.
// - Writing 0 to that flag between array write and launch aborts the partial sequence.
// - Such an abort sets the access error flag.
// - A sequence out of the order array write, command write, launch is refused.
// - A command-complete flag shows when the launched command has finished.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_DIVIDER     8'h00
`define OFS_STATUS      8'h01
`define OFS_COMMAND     8'h02
`define OFS_ARRAY_ADDR  8'h03
`define OFS_ARRAY_DATA  8'h04
`define OFS_IRQ_STATUS  8'h05
`define OFS_IRQ_ENABLE  8'h06
`define OFS_IRQ_CLEAR   8'h07
`define OFS_OP_ADDR     8'h08
`define OFS_OP_DATA     8'h09

// ----------------------------------------
// Status register bits and the divider register set bit
// ----------------------------------------
`define BIT_CBE         7
`define BIT_CCF         6
`define BIT_ACCERR      4
`define BIT_DIVSET      7

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_BLANK       8'h05
`define CMD_BYTE        8'h20
`define CMD_BURST       8'h25
`define CMD_PAGE_ERASE  8'h40
`define CMD_MASS_ERASE  8'h41

// ----------------------------------------
// Array geometry, resets and timing
// ----------------------------------------
`define PAGE_BITS       9
`define ADDR_W          16
`define DIV_RESET       7'h00
`define OP_TIME_NS      1000
`define CLK_PERIOD_NS   50
`define OP_CYCLES       ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** flash_seq_pkg.sv ***
// Types for the flash command sequencer.
// Assumes the map header for all numbers.
package flash_seq_pkg;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD, SEQ_BUSY} seq_e;
endpackage : flash_seq_pkg

// *** flash_command_sequencer.sv ***
// Flash command sequencer: latches array write, command and launch, runs a timed array operation.
// Assumes a single-cycle register master on ref_clk and a flash array reached over the op port.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "flash_seq_map.svh"

module flash_command_sequencer
   import flash_seq_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               reset,
   // Register port
   input  wire logic [7:0]         regAddr,
   input  wire logic [7:0]         regWdata,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   output logic      [7:0]         regRdata,
   // Array write that opens a sequence
   input  wire logic               arrayWrite,
   input  wire logic [`ADDR_W-1:0] arrayAddr,
   input  wire logic [7:0]         arrayData,
   // Array operation
   output logic                    opStart,
   output logic      [7:0]         opCommand,
   output logic      [`ADDR_W-1:0] opAddr,
   output logic      [7:0]         opData,
   // Interrupt
   output logic                    irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   seq_e               state_q,  state_d;
   logic [`ADDR_W-1:0] addr_q;
   logic [7:0]         data_q;
   logic [7:0]         cmd_q;
   logic               cbe_q;
   logic               ccf_q;
   logic               accerr_q;
   logic [6:0]         div_q;
   logic               divSet_q;
   logic [15:0]        opCnt_q;
   logic [2:0]         irqStat_q;
   logic [2:0]         irqEn_q;

   function automatic logic valid_cmd(input logic [7:0] c);
      valid_cmd = (c == `CMD_BLANK) || (c == `CMD_BYTE) || (c == `CMD_BURST)
               || (c == `CMD_PAGE_ERASE) || (c == `CMD_MASS_ERASE);
   endfunction : valid_cmd

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire wrStatus  = regWrite && (regAddr == `OFS_STATUS);
   wire wrCommand = regWrite && (regAddr == `OFS_COMMAND);
   wire wrDivider = regWrite && (regAddr == `OFS_DIVIDER);
   wire wrIrqEn   = regWrite && (regAddr == `OFS_IRQ_ENABLE);
   wire wrIrqClr  = regWrite && (regAddr == `OFS_IRQ_CLEAR);
   wire launchWr  = wrStatus && regWdata[`BIT_CBE];
   wire abortWr   = wrStatus && !regWdata[`BIT_CBE];
   wire errClrWr  = wrStatus && regWdata[`BIT_ACCERR];
   // Any departure from order is refused; error flag blocks new sequences
   wire seqOpen   = arrayWrite && (state_q == SEQ_IDLE) && !accerr_q && divSet_q;
   wire cmdOk     = wrCommand && (state_q == SEQ_ADDR) && valid_cmd(regWdata);
   wire doLaunch  = launchWr && (state_q == SEQ_CMD) && !arrayWrite;
   wire doAbort   = abortWr && ((state_q == SEQ_ADDR) || (state_q == SEQ_CMD));
   wire badOrder  = (wrCommand && !cmdOk && state_q != SEQ_BUSY)
                 || (launchWr && (state_q == SEQ_ADDR))
                 || (arrayWrite && (state_q == SEQ_ADDR || state_q == SEQ_CMD));
   wire opDone    = (state_q == SEQ_BUSY) && (opCnt_q == 16'h0001);
   wire errSet    = doAbort || badOrder;
   // Page erase acts on a whole page: low address bits dropped; erase data ignored
   wire isErase   = (cmd_q == `CMD_PAGE_ERASE) || (cmd_q == `CMD_MASS_ERASE);
   wire isNoData  = isErase || (cmd_q == `CMD_BLANK);
   wire [`ADDR_W-1:0] pageAddr = {addr_q[`ADDR_W-1:`PAGE_BITS], {`PAGE_BITS{1'b0}}};
   wire [`ADDR_W-1:0] launchAddr = (cmd_q == `CMD_PAGE_ERASE) ? pageAddr : addr_q;
   wire [2:0] irqEvents = {errSet, opDone, doLaunch};

   always_comb begin
      state_d = state_q;
      case (state_q)
         SEQ_IDLE: begin
            if (seqOpen) state_d = SEQ_ADDR;
         end
         SEQ_ADDR: begin
            if (doAbort || badOrder) state_d = SEQ_IDLE;
            else if (cmdOk) state_d = SEQ_CMD;
         end
         SEQ_CMD: begin
            if (doAbort || badOrder) state_d = SEQ_IDLE;
            else if (doLaunch) state_d = SEQ_BUSY;
         end
         SEQ_BUSY: begin
            if (opDone) state_d = SEQ_IDLE;
         end
         default: state_d = SEQ_IDLE;
      endcase
   end

   // ----------------------------------------
   // Sequence registers
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= SEQ_IDLE;
         addr_q  <= '0;
         data_q  <= 8'h00;
         cmd_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         if (seqOpen) begin
            addr_q <= arrayAddr;
            data_q <= arrayData;
         end
         if (cmdOk) cmd_q <= regWdata;
      end
   end

   // ----------------------------------------
   // Flags; the accerr set wins over a clear in the same cycle, the launch clear wins for cbe and ccf
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cbe_q    <= 1'b1;
         ccf_q    <= 1'b1;
         accerr_q <= 1'b0;
      end else begin
         if (doLaunch) cbe_q <= 1'b0;
         else if (opDone || doAbort) cbe_q <= 1'b1;
         if (doLaunch) ccf_q <= 1'b0;
         else if (opDone) ccf_q <= 1'b1;
         if (errSet) accerr_q <= 1'b1;
         else if (errClrWr) accerr_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Divider: first write after reset only
   // ----------------------------------------
   // Later writes ignored so a stray store cannot retime an operation in flight
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         div_q    <= `DIV_RESET;
         divSet_q <= 1'b0;
      end else if (wrDivider && !divSet_q) begin
         div_q    <= regWdata[6:0];
         divSet_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // Array operation timer
   // ----------------------------------------
   // Duration grows by one cycle per divider count so a slow flash clock gives a longer operation
   wire [15:0] opLoad = 16'(`OP_CYCLES) + {9'h000, div_q};

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         opCnt_q   <= 16'h0000;
         opStart   <= 1'b0;
         opCommand <= 8'h00;
         opAddr    <= '0;
         opData    <= 8'h00;
      end else begin
         opStart <= doLaunch;
         if (doLaunch) begin
            opCnt_q   <= opLoad;
            opCommand <= cmd_q;
            opAddr    <= launchAddr;
            opData    <= isNoData ? 8'h00 : data_q;
         end else if (opCnt_q != 16'h0000) begin
            opCnt_q <= opCnt_q - 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Interrupts: sticky status, enable, write-one clear
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irqStat_q <= 3'h0;
         irqEn_q   <= 3'h0;
         irq       <= 1'b0;
      end else begin
         irqStat_q <= irqEvents | (irqStat_q & ~(wrIrqClr ? regWdata[2:0] : 3'h0));
         if (wrIrqEn) irqEn_q <= regWdata[2:0];
         irq <= |(irqStat_q & irqEn_q);
      end
   end

   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   logic [7:0] rdMux;
   always_comb begin
      case (regAddr)
         `OFS_DIVIDER:    rdMux = {divSet_q, div_q};
         `OFS_STATUS:     rdMux = {cbe_q, ccf_q, 1'b0, accerr_q, 4'h0};
         `OFS_COMMAND:    rdMux = cmd_q;
         `OFS_ARRAY_ADDR: rdMux = addr_q[7:0];
         `OFS_ARRAY_DATA: rdMux = data_q;
         `OFS_IRQ_STATUS: rdMux = {5'h00, irqStat_q};
         `OFS_IRQ_ENABLE: rdMux = {5'h00, irqEn_q};
         `OFS_OP_ADDR:    rdMux = addr_q[15:8];
         default:         rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) regRdata <= 8'h00;
      else regRdata <= regRead ? rdMux : 8'h00;
   end

   // ----------------------------------------
   // Check helpers
   // ----------------------------------------
   // Counted apart from the timer so the length check does not lean on the logic it guards
   logic [7:0] busyLen_q;
   logic [7:0] busyWant_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         busyLen_q  <= 8'h00;
         busyWant_q <= 8'h00;
      end else if (doLaunch) begin
         busyLen_q  <= 8'h00;
         busyWant_q <= 8'(`OP_CYCLES) + {1'b0, div_q};
      end else if (state_q == SEQ_BUSY) begin
         busyLen_q <= busyLen_q + 8'h01;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_launch_clears_cbe: assert property (@(posedge ref_clk) disable iff (reset)
      doLaunch |=> !cbe_q && opStart) else $error("launch did not clear buffer flag");
   a_abort_sets_err: assert property (@(posedge ref_clk) disable iff (reset)
      doAbort |=> accerr_q && state_q == SEQ_IDLE) else $error("abort did not set error");
   a_abort_no_start: assert property (@(posedge ref_clk) disable iff (reset)
      doAbort |=> !opStart && cbe_q) else $error("aborted sequence started");
   a_order_refused: assert property (@(posedge ref_clk) disable iff (reset)
      opStart |-> $past(state_q) == SEQ_CMD) else $error("start out of order");
   a_ccf_low_busy: assert property (@(posedge ref_clk) disable iff (reset)
      doLaunch |=> !ccf_q [*2]) else $error("complete flag not cleared");
   a_ccf_on_done: assert property (@(posedge ref_clk) disable iff (reset)
      opDone |=> ccf_q && cbe_q) else $error("complete flag not set at end");
   a_page_aligned: assert property (@(posedge ref_clk) disable iff (reset)
      opStart && opCommand == `CMD_PAGE_ERASE |-> opAddr[`PAGE_BITS-1:0] == '0)
      else $error("page erase not page aligned");
   a_erase_no_data: assert property (@(posedge ref_clk) disable iff (reset)
      opStart && opCommand != `CMD_BYTE && opCommand != `CMD_BURST |-> opData == 8'h00)
      else $error("erase carried data");
   a_cmd_valid: assert property (@(posedge ref_clk) disable iff (reset)
      cmdOk |=> valid_cmd(cmd_q) && cmd_q == $past(regWdata) && state_q == SEQ_CMD)
      else $error("invalid command latched");
   a_latch_addr: assert property (@(posedge ref_clk) disable iff (reset)
      seqOpen |=> addr_q == $past(arrayAddr) && data_q == $past(arrayData)) else $error("array write not latched");
   a_div_once: assert property (@(posedge ref_clk) disable iff (reset)
      divSet_q |=> $stable(div_q)) else $error("divider rewritten");

   // ----------------------------------------
   // Refusal, timing, busy flag and op field checks
   // ----------------------------------------
   a_bad_code_refused: assert property (@(posedge ref_clk) disable iff (reset)
      wrCommand && state_q == SEQ_ADDR && !valid_cmd(regWdata) |=> accerr_q && state_q == SEQ_IDLE)
      else $error("invalid command code accepted");
   a_early_launch: assert property (@(posedge ref_clk) disable iff (reset)
      launchWr && state_q == SEQ_ADDR |=> accerr_q && !opStart && state_q == SEQ_IDLE)
      else $error("launch without command accepted");
   a_second_write: assert property (@(posedge ref_clk) disable iff (reset)
      arrayWrite && state_q == SEQ_CMD |=> accerr_q && !opStart && state_q == SEQ_IDLE)
      else $error("second array write accepted");
   a_error_blocks_open: assert property (@(posedge ref_clk) disable iff (reset)
      arrayWrite && accerr_q && state_q == SEQ_IDLE |=> state_q == SEQ_IDLE)
      else $error("sequence opened with error set");
   a_err_set_wins: assert property (@(posedge ref_clk) disable iff (reset)
      errSet |=> accerr_q)
      else $error("error flag not set");
   a_busy_flags: assert property (@(posedge ref_clk) disable iff (reset)
      state_q == SEQ_BUSY |-> !cbe_q && !ccf_q)
      else $error("flags not cleared while busy");
   a_busy_min_time: assert property (@(posedge ref_clk) disable iff (reset)
      doLaunch |=> ##19 (state_q == SEQ_BUSY && !ccf_q))
      else $error("operation ended early");
   a_done_in_time: assert property (@(posedge ref_clk) disable iff (reset)
      doLaunch |=> ##[20:147] ccf_q)
      else $error("operation did not end in time");
   a_op_length: assert property (@(posedge ref_clk) disable iff (reset)
      opDone |-> (busyLen_q + 8'h01) == busyWant_q)
      else $error("operation length wrong");
   a_op_fields_hold: assert property (@(posedge ref_clk) disable iff (reset)
      !opStart |-> $stable(opCommand) && $stable(opAddr)
                && $stable(opData))
      else $error("op fields changed without launch");
   a_byte_latched: assert property (@(posedge ref_clk) disable iff (reset)
      doLaunch && cmd_q == `CMD_BYTE
      |=> opAddr == $past(addr_q) && opData == $past(data_q))
      else $error("program lost latched address or data");

endmodule : flash_command_sequencer

// *** flash_array_model.sv ***
// Behavioural flash array that receives the sequencer's launched operations.
// Assumes opStart is a one-cycle pulse with the op fields valid beside it.
`timescale 1ns/1ps
`include "flash_seq_map.svh"

module flash_array_model (
   // Clock
   input  wire logic               ref_clk,
   // Array operation
   input  wire logic               opStart,
   input  wire logic [7:0]         opCommand,
   input  wire logic [`ADDR_W-1:0] opAddr,
   input  wire logic [7:0]         opData,
   // Observation
   output int                      launches,
   output int                      reprograms
);
   bit progMap [int];

   initial begin
      launches   = 0;
      reprograms = 0;
   end

   // A second program without erase would disturb stored data, so it is counted
   always @(posedge ref_clk) begin
      if (opStart === 1'b1) begin
         launches++;
         if (opCommand == `CMD_BYTE || opCommand == `CMD_BURST) begin
            if (progMap.exists(int'(opAddr))) reprograms++;
            progMap[int'(opAddr)] = 1'b1;
         end
         if (opCommand == `CMD_PAGE_ERASE) begin
            for (int i = 0; i < 512; i++) progMap.delete(int'({opAddr[15:9], i[8:0]}));
         end
         if (opCommand == `CMD_MASS_ERASE) progMap.delete();
      end
   end
endmodule : flash_array_model

// *** tb_top.sv ***
// Self-checking bench for the flash command sequencer.
// Assumes the design's map header; one 20 MHz clock and a synchronous reset.
`timescale 1ns/1ps
`include "flash_seq_map.svh"

module tb_top;
   localparam logic [6:0] DIV = 7'h03;
   logic                  ref_clk, reset, regWrite, regRead, arrayWrite, rdPend;
   logic [7:0]            regAddr, regWdata, arrayData, d, ed;
   logic [`ADDR_W-1:0]    arrayAddr, a, ea;
   wire logic [7:0]       regRdata, opCommand, opData;
   wire logic [`ADDR_W-1:0] opAddr;
   wire logic             opStart, irq;
   int                    launches, reprograms, fails, checks_done, cycles, seed;
   logic [7:0]            expQ [$];
   logic [31:0]           opQ [$];
   logic [7:0]            codes [5] = '{`CMD_BLANK, `CMD_BYTE, `CMD_BURST, `CMD_PAGE_ERASE, `CMD_MASS_ERASE};

   flash_command_sequencer dut_u (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .arrayWrite(arrayWrite),
      .arrayAddr(arrayAddr), .arrayData(arrayData), .opStart(opStart), .opCommand(opCommand),
      .opAddr(opAddr), .opData(opData), .irq(irq));
   flash_array_model array_u (.ref_clk(ref_clk), .opStart(opStart), .opCommand(opCommand), .opAddr(opAddr),
      .opData(opData), .launches(launches), .reprograms(reprograms));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // A gap cycle before each strobe keeps every signal to one assignment per time step
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      @(posedge ref_clk);
      regAddr  <= ad;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge ref_clk);
      regAddr <= ad;
      regRead <= 1'b1;
      expQ.push_back(e);
      @(posedge ref_clk);
      regRead <= 1'b0;
   endtask : rd

   task automatic aw(input logic [`ADDR_W-1:0] ad, input logic [7:0] v);
      @(posedge ref_clk);
      arrayAddr  <= ad;
      arrayData  <= v;
      arrayWrite <= 1'b1;
      @(posedge ref_clk);
      arrayWrite <= 1'b0;
   endtask : aw

   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // Read data stand only in the cycle after the strobe; op fields beside opStart
   always @(posedge ref_clk) begin
      if (rdPend === 1'b1) chk("regRdata", expQ.size() ? expQ.pop_front() : 8'hxx, regRdata);
      if (opStart === 1'b1) chk("op fields", opQ.size() ? opQ.pop_front() : 32'hx, {opCommand, opAddr, opData});
      rdPend = regRead;
      cycles++;
      if (cycles == 3000) begin
         fails++;
         $display("MISMATCH run length expected below 3000 seen 3000");
         tally_and_finish();
      end
   end

   initial begin
      {reset, regWrite, regRead, arrayWrite} = 4'b1000;
      {regAddr, regWdata, arrayData, arrayAddr} = 40'h0;
      seed = 54938;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`OFS_STATUS, 8'hc0);
      wr(`OFS_IRQ_ENABLE, 8'h03);
      wr(`OFS_DIVIDER, {1'b0, DIV});
      wr(`OFS_DIVIDER, 8'h7f);
      rd(`OFS_DIVIDER, {1'b1, DIV});
      rd(8'h0f, 8'h00);
      foreach (codes[i]) begin
         a  = 16'($random(seed));
         d  = 8'($random(seed));
         ea = (codes[i] == `CMD_PAGE_ERASE) ? {a[15:9], 9'h000} : a;
         ed = (codes[i] == `CMD_BYTE || codes[i] == `CMD_BURST) ? d : 8'h00;
         opQ.push_back({codes[i], ea, ed});
         aw(a, d);
         wr(`OFS_COMMAND, codes[i]);
         wr(`OFS_STATUS, 8'h80);
         rd(`OFS_STATUS, 8'h00);
         rd(`OFS_COMMAND, codes[i]);
         rd(`OFS_ARRAY_ADDR, a[7:0]);
         rd(`OFS_OP_ADDR, a[15:8]);
         rd(`OFS_ARRAY_DATA, d);
         repeat (`OP_CYCLES + DIV + 4) @(posedge ref_clk);
         rd(`OFS_STATUS, 8'hc0);
         rd(`OFS_IRQ_STATUS, 8'h03);
         #1 chk("irq", 1'b1, irq);
         wr(`OFS_IRQ_CLEAR, 8'h07);
         rd(`OFS_IRQ_STATUS, 8'h00);
         #1 chk("irq", 1'b0, irq);
      end
      // Out-of-order sequences: command alone, bad code, launch without command, second array write
      for (int k = 0; k < 4; k++) begin
         if (k != 0) aw(a, d);
         if (k != 2) wr(`OFS_COMMAND, (k == 1) ? 8'h33 : `CMD_BYTE);
         if (k == 3) aw(a, d);
         wr(`OFS_STATUS, 8'h80);
         rd(`OFS_STATUS, 8'hd0);
         wr(`OFS_STATUS, 8'h10);
      end
      aw(a, d);
      wr(`OFS_STATUS, 8'h00);
      rd(`OFS_STATUS, 8'hd0);
      #1 chk("irq masked", 1'b0, irq);
      aw(a, d);
      wr(`OFS_COMMAND, `CMD_BYTE);
      wr(`OFS_STATUS, 8'h80);
      rd(`OFS_IRQ_STATUS, 8'h04);
      wr(`OFS_IRQ_ENABLE, 8'h04);
      rd(`OFS_STATUS, 8'hd0);
      #1 chk("irq enabled", 1'b1, irq);
      wr(`OFS_IRQ_CLEAR, 8'h04);
      wr(`OFS_STATUS, 8'h10);
      rd(`OFS_STATUS, 8'hc0);
      #1 chk("irq cleared", 1'b0, irq);
      // Second reset in mid-run: the divider takes one write again and gates array writes until then
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`OFS_STATUS, 8'hc0);
      rd(`OFS_DIVIDER, {1'b0, `DIV_RESET});
      aw(a, d);
      wr(`OFS_DIVIDER, {1'b0, DIV});
      wr(`OFS_DIVIDER, 8'h7f);
      rd(`OFS_DIVIDER, {1'b1, DIV});
      rd(`OFS_STATUS, 8'hc0);
      repeat (4) @(posedge ref_clk);
      chk("launches", 32'd5, launches);
      chk("reprograms", 32'd0, reprograms);
      chk("pending", 32'd0, expQ.size() + opQ.size());
      tally_and_finish();
   end
endmodule : tb_top
